// ===== hdl/sct_pkg.sv
// command decoder package: command codes, modes, input bundle, size constants
// assumes a single 50 MHz clock and a synchronous active-low reset
package sct_pkg;
    localparam int   CLK_MHZ       = 50;
    localparam int   BURST_LEN     = 4;              // fixed burst of four beats
    localparam int   FIFO_DEPTH    = 16;
    localparam int   DATA_W        = 16;
    localparam int   BANKS         = 2;
    localparam int   A10_BIT       = 10;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [1:0] BEAT_RST  = 2'h0;

    // decoded command, encoding of rows of the truth table
    typedef enum logic [3:0] {
        SCT_CMD_DESEL   = 4'h0,
        SCT_CMD_NOP     = 4'h1,
        SCT_CMD_ACT     = 4'h2,
        SCT_CMD_READ    = 4'h3,
        SCT_CMD_WRITE   = 4'h4,
        SCT_CMD_PRE     = 4'h5,
        SCT_CMD_MRS     = 4'h6,
        SCT_CMD_AREF    = 4'h7,
        SCT_CMD_BSTOP   = 4'h8,
        SCT_CMD_SREF_IN = 4'h9
    } sct_cmd_type;

    // operating mode
    typedef enum logic [2:0] {
        SCT_MODE_NORMAL  = 3'h0,
        SCT_MODE_SUSPEND = 3'h1,
        SCT_MODE_PDOWN   = 3'h2,
        SCT_MODE_SREF    = 3'h3
    } sct_mode_type;

    // command pins sampled on the rising edge
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        ba;
        logic [10:0] addr;
        logic [1:0]  dqm;
    } sct_pins_type;

    // write beat pushed into the data fifo
    typedef struct packed {
        logic              bank;
        logic [DATA_W-1:0] data;
        logic [1:0]        mask;
    } sct_beat_type;
endpackage

// ===== hdl/sct_fifo.sv
// small flip-flop fifo with valid/ready on both sides
// assumes one clock domain and synchronous active-low reset
`timescale 1ns/1ps
module sct_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } sct_fifo_st_type;

    sct_fifo_st_type st_r;
    sct_fifo_st_type st_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic             push;
    logic             pop;

    // --------------------------------------------------------------
    // handshake
    // --------------------------------------------------------------
    assign in_ready_o  = (st_r.cnt != DEPTH[AW:0]);
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o  = mem_r[st_r.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer and count update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage has no reset; contents are qualified by the count
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[st_r.wp] <= in_data_i;
        end
    end

    fifo_no_overflow_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.cnt <= DEPTH[AW:0])
        else $error("fifo count beyond depth");
endmodule

// ===== hdl/sct_decoder.sv
// command decoder and operating-mode state of a two-bank 16-bit dram
// assumes pins are synchronous to clk_i; the write side drains through a fifo
`timescale 1ns/1ps

module sct_decoder (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire sct_pkg::sct_pins_type         pins_i,
    input  wire logic [sct_pkg::DATA_W-1:0]    dq_i,
    output logic [sct_pkg::DATA_W-1:0]         dq_o,
    output logic [1:0]                         dq_oe_o,
    output logic [sct_pkg::BANKS-1:0]          bank_open_o,
    output sct_pkg::sct_mode_type              mode_o,
    output sct_pkg::sct_cmd_type               cmd_o,
    output logic                               cmd_valid_o,
    output logic                               burst_o,
    output logic                               auto_pre_o,
    output logic                               mrs_o,
    output logic                               refresh_o,
    output logic                               illegal_o,
    output logic                               wr_valid_o,
    input  wire logic                          wr_ready_i,
    output sct_pkg::sct_beat_type              wr_beat_o,
    input  wire logic [sct_pkg::DATA_W-1:0]    rd_data_i
);
    // all state in one struct
    typedef struct packed {
        logic                          cke_prev;
        sct_pkg::sct_mode_type         mode;
        logic                          susp_pend;
        logic                          resume_pend;
        logic [sct_pkg::BANKS-1:0]     open;
        logic                          rd_burst;
        logic                          wr_burst;
        logic                          bank;
        logic                          ap;
        logic [1:0]                    beat;
        sct_pkg::sct_cmd_type          cmd;
        logic                          cmd_valid;
        logic                          mrs;
        logic                          refresh;
        logic                          illegal;
        logic [sct_pkg::DATA_W-1:0]    dq;
        logic [1:0]                    oe;
    } sct_st_type;

    sct_st_type           st_r;
    sct_st_type           st_nxt;
    sct_pkg::sct_cmd_type cmd;
    sct_pkg::sct_beat_type beat_in;
    logic                 fifo_in_valid;
    logic                 fifo_in_ready;
    logic                 idle;
    logic                 in_burst;
    logic                 halted;
    logic                 restart;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // strobes decoded from the current edge, cke from both edges
    always_comb begin
        if (pins_i.cs_n) begin
            cmd = sct_pkg::SCT_CMD_DESEL;
        end else begin
            unique case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
                3'h7:    cmd = sct_pkg::SCT_CMD_NOP;
                3'h6:    cmd = sct_pkg::SCT_CMD_BSTOP;
                3'h3:    cmd = sct_pkg::SCT_CMD_ACT;
                3'h5:    cmd = sct_pkg::SCT_CMD_READ;
                3'h4:    cmd = sct_pkg::SCT_CMD_WRITE;
                3'h2:    cmd = sct_pkg::SCT_CMD_PRE;
                3'h0:    cmd = sct_pkg::SCT_CMD_MRS;
                default: cmd = pins_i.cke ? sct_pkg::SCT_CMD_AREF
                                          : sct_pkg::SCT_CMD_SREF_IN;
            endcase
        end
    end

    assign idle     = (st_r.open == '0);
    assign in_burst = st_r.rd_burst || st_r.wr_burst;
    // internal operation frozen while suspended or in a low-power mode
    assign halted   = (st_r.mode != sct_pkg::SCT_MODE_NORMAL) || st_r.susp_pend;

    // ----------------------------------------------------------------
    // mode and bank state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.cke_prev  = pins_i.cke;
        st_nxt.cmd_valid = 1'b0;
        st_nxt.mrs       = 1'b0;
        st_nxt.refresh   = 1'b0;
        st_nxt.illegal   = 1'b0;
        st_nxt.oe        = 2'h0;
        fifo_in_valid    = 1'b0;
        restart          = 1'b0;
        beat_in          = '{bank: st_r.bank, data: dq_i, mask: pins_i.dqm};

        unique case (st_r.mode)
            sct_pkg::SCT_MODE_NORMAL: begin
                if (st_r.cke_prev && !pins_i.cke) begin
                    // self refresh entry only from idle with refresh encoding
                    if (cmd == sct_pkg::SCT_CMD_SREF_IN && idle) begin
                        st_nxt.mode = sct_pkg::SCT_MODE_SREF;
                    end else if (!idle || in_burst) begin
                        st_nxt.susp_pend = 1'b1;
                    end else begin
                        st_nxt.mode = sct_pkg::SCT_MODE_PDOWN;
                    end
                end
                if (st_r.susp_pend) begin
                    // one clock after cke registered low the device freezes
                    st_nxt.susp_pend = 1'b0;
                    st_nxt.mode      = sct_pkg::SCT_MODE_SUSPEND;
                    // a cke rise on this edge must not be lost on the way in
                    if (!st_r.cke_prev && pins_i.cke) begin
                        st_nxt.resume_pend = 1'b1;
                    end
                end
            end
            sct_pkg::SCT_MODE_SUSPEND: begin
                if (st_r.resume_pend) begin
                    st_nxt.resume_pend = 1'b0;
                    st_nxt.mode        = sct_pkg::SCT_MODE_NORMAL;
                end else if (!st_r.cke_prev && pins_i.cke) begin
                    st_nxt.resume_pend = 1'b1;
                end
            end
            sct_pkg::SCT_MODE_PDOWN, sct_pkg::SCT_MODE_SREF: begin
                // other pins ignored; only cke rising leaves
                if (!st_r.cke_prev && pins_i.cke) begin
                    st_nxt.mode = sct_pkg::SCT_MODE_NORMAL;
                end
            end
            default: st_nxt.mode = sct_pkg::SCT_MODE_NORMAL;
        endcase

        // commands are taken only with cke high on the previous edge
        if (!halted && st_r.cke_prev) begin
            st_nxt.cmd       = cmd;
            st_nxt.cmd_valid = 1'b1;
            unique case (cmd)
                sct_pkg::SCT_CMD_ACT: begin
                    if (st_r.open[pins_i.ba]) begin
                        st_nxt.illegal = 1'b1;
                    end else begin
                        st_nxt.open[pins_i.ba] = 1'b1;
                    end
                end
                sct_pkg::SCT_CMD_MRS: begin
                    if (idle) st_nxt.mrs = 1'b1;
                    else      st_nxt.illegal = 1'b1;
                end
                sct_pkg::SCT_CMD_AREF: begin
                    if (idle) st_nxt.refresh = 1'b1;
                    else      st_nxt.illegal = 1'b1;
                end
                sct_pkg::SCT_CMD_READ, sct_pkg::SCT_CMD_WRITE: begin
                    if (!st_r.open[pins_i.ba] || st_r.ap) begin
                        st_nxt.illegal = 1'b1;
                    end else begin
                        st_nxt.bank     = pins_i.ba;
                        st_nxt.ap       = pins_i.addr[sct_pkg::A10_BIT];
                        st_nxt.beat     = sct_pkg::BEAT_RST;
                        st_nxt.rd_burst = (cmd == sct_pkg::SCT_CMD_READ);
                        st_nxt.wr_burst = (cmd == sct_pkg::SCT_CMD_WRITE);
                        restart         = 1'b1;
                    end
                end
                sct_pkg::SCT_CMD_PRE: begin
                    if (pins_i.addr[sct_pkg::A10_BIT]) begin
                        st_nxt.open = '0;
                    end else begin
                        st_nxt.open[pins_i.ba] = 1'b0;
                    end
                    st_nxt.rd_burst = 1'b0;
                    st_nxt.wr_burst = 1'b0;
                end
                sct_pkg::SCT_CMD_BSTOP: begin
                    // the controller only stops full-page bursts
                    st_nxt.rd_burst = 1'b0;
                    st_nxt.wr_burst = 1'b0;
                end
                default: ;
            endcase
        end

        // burst beats advance only when not frozen; write beats stall on a full fifo
        // a new read or write this edge restarts the burst instead of advancing
        if (!halted && in_burst && !restart) begin
            if (st_r.wr_burst) begin
                fifo_in_valid = !pins_i.dqm[0] || !pins_i.dqm[1];
            end else if (st_r.rd_burst) begin
                st_nxt.dq = rd_data_i;
                st_nxt.oe = ~pins_i.dqm;
            end
            if (!st_r.wr_burst || fifo_in_ready || !fifo_in_valid) begin
                st_nxt.beat = st_r.beat + 2'h1;
                if (st_r.beat == sct_pkg::BEAT_LAST) begin
                    st_nxt.rd_burst = 1'b0;
                    st_nxt.wr_burst = 1'b0;
                    if (st_r.ap) begin
                        st_nxt.open[st_r.bank] = 1'b0;
                        st_nxt.ap              = 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r      <= '0;
            st_r.mode <= sct_pkg::SCT_MODE_NORMAL;
            st_r.cmd  <= sct_pkg::SCT_CMD_DESEL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // write data path; the fifo drains toward the array
    sct_fifo #(
        .WIDTH ($bits(sct_pkg::sct_beat_type)),
        .DEPTH (sct_pkg::FIFO_DEPTH)
    ) sct_fifo_inst (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (beat_in),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_beat_o)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign dq_o        = st_r.dq;
    assign dq_oe_o     = st_r.oe;
    assign bank_open_o = st_r.open;
    assign mode_o      = st_r.mode;
    assign cmd_o       = st_r.cmd;
    assign cmd_valid_o = st_r.cmd_valid;
    assign burst_o     = in_burst;
    assign auto_pre_o  = st_r.ap;
    assign mrs_o       = st_r.mrs;
    assign refresh_o   = st_r.refresh;
    assign illegal_o   = st_r.illegal;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence cke_fall_open_s;
        st_r.cke_prev && !pins_i.cke && !idle && st_r.mode == sct_pkg::SCT_MODE_NORMAL;
    endsequence
    sequence suspend_after_s;
        ##2 st_r.mode == sct_pkg::SCT_MODE_SUSPEND;
    endsequence

    suspend_entry_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cke_fall_open_s |-> suspend_after_s)
        else $error("clock suspend not entered two edges after cke fall");
    burst_no_pdown_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (in_burst && st_r.mode == sct_pkg::SCT_MODE_NORMAL && st_r.cke_prev && !pins_i.cke)
        |=> st_r.mode != sct_pkg::SCT_MODE_PDOWN)
        else $error("power down entered during a burst");
    pre_all_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!halted && st_r.cke_prev && cmd == sct_pkg::SCT_CMD_PRE && pins_i.addr[sct_pkg::A10_BIT])
        |=> st_r.open == '0)
        else $error("precharge all left a bank open");
    act_opens_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!halted && st_r.cke_prev && cmd == sct_pkg::SCT_CMD_ACT) |=> st_r.open[$past(pins_i.ba)])
        else $error("activate did not open bank");
    rd_closed_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!halted && st_r.cke_prev && cmd == sct_pkg::SCT_CMD_READ && !st_r.open[pins_i.ba])
        |=> illegal_o)
        else $error("read to closed bank not flagged");
    sref_entry_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_r.mode == sct_pkg::SCT_MODE_NORMAL && !st_r.susp_pend && st_r.cke_prev
         && cmd == sct_pkg::SCT_CMD_SREF_IN && idle) |=> st_r.mode == sct_pkg::SCT_MODE_SREF)
        else $error("self refresh not entered");
    deselect_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!halted && st_r.cke_prev && pins_i.cs_n) |=> cmd_o == sct_pkg::SCT_CMD_DESEL && !illegal_o)
        else $error("deselect decoded wrongly");
    mask_drive_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!halted && st_r.rd_burst) |=> (dq_oe_o & $past(pins_i.dqm)) == 2'h0)
        else $error("masked read byte drove the bus");
    pdown_exit_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_r.mode == sct_pkg::SCT_MODE_PDOWN && !st_r.cke_prev && pins_i.cke)
        |=> st_r.mode == sct_pkg::SCT_MODE_NORMAL)
        else $error("power down not left on cke rise");
endmodule

// ===== bench/sct_ctrl_model.sv
// controller-side model: turns bench requests into command pin levels
// assumes the bench changes its requests only at falling clock edges
`timescale 1ns/1ps
module sct_ctrl_model (
    input  wire logic                  clk_i,
    input  wire sct_pkg::sct_pins_type req_i,
    output sct_pkg::sct_pins_type      pins_o
);
    logic cke_r;

    // ----------------------------------------
    // previous clock enable, as the device sees it
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        cke_r <= pins_o.cke;
    end

    // pins settle half a period before the rising edge
    always_comb begin
        pins_o = req_i;
        // bursts are never full page here, so burst stop turns into nop
        if (!req_i.cs_n && req_i.ras_n && req_i.cas_n && !req_i.we_n) begin
            pins_o.we_n = 1'b1;
        end
        // the exit edge of a low-power mode carries a nop when cs_n is low, else a deselect
        if (!cke_r && req_i.cke && !req_i.cs_n) begin
            {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = 3'h7;
        end
    end
endmodule

// ===== bench/sdram_command_truth_table_test.sv
// self-checking bench of the command decoder with a controller model in front
// assumes the decoder, its fifo and the package are compiled first
`timescale 1ns/1ps
module sdram_command_truth_table_test;
    logic                  clk_i;
    logic                  rst_n_i;
    sct_pkg::sct_pins_type req;
    sct_pkg::sct_pins_type pins;
    sct_pkg::sct_beat_type beat;
    sct_pkg::sct_mode_type mode;
    sct_pkg::sct_cmd_type  cmd;
    sct_pkg::sct_cmd_type  last_cmd;
    logic [15:0]           dq;
    logic [15:0]           dq_o;
    logic [15:0]           rd_data;
    logic [1:0]            dq_oe;
    logic [1:0]            bank_open;
    logic                  cmd_valid, burst, auto_pre, mrs, refresh, illegal, wr_valid, wr_ready;
    int                    num_errors, cmp_count, n, i;
    int                    seed = 32'hb6fc;
    logic [3:0]            code_t [6] = '{4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0};
    int                    kind_t [6] = '{0, 0, 0, 0, 2, 3};
    sct_pkg::sct_cmd_type  exp_t  [6] = '{sct_pkg::SCT_CMD_ACT, sct_pkg::SCT_CMD_READ, sct_pkg::SCT_CMD_WRITE,
                                          sct_pkg::SCT_CMD_PRE, sct_pkg::SCT_CMD_AREF, sct_pkg::SCT_CMD_MRS};

    sct_ctrl_model sct_ctrl_model_inst (.clk_i(clk_i), .req_i(req), .pins_o(pins));
    sct_decoder sct_decoder_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .dq_i(dq), .dq_o(dq_o),
        .dq_oe_o(dq_oe), .bank_open_o(bank_open), .mode_o(mode), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
        .burst_o(burst), .auto_pre_o(auto_pre), .mrs_o(mrs), .refresh_o(refresh), .illegal_o(illegal),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_beat_o(beat), .rd_data_i(rd_data));

    // ----------------------------------------
    // clock and array-side random data
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        rd_data <= 16'($random(seed));
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_of_test();
        $display("errors %0d, compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // new levels at the falling edge; address bits below a10 are random
    task automatic issue(input logic cke, input logic [3:0] code, input logic ba, input logic a10);
        @(negedge clk_i);
        req = '{cke, code[3], code[2], code[1], code[0], ba, {a10, 10'($random(seed))}, req.dqm};
    endtask
    function automatic logic pulse(input int k);
        case (k)
            0: return cmd_valid;
            1: return illegal;
            2: return refresh;
            default: return mrs;
        endcase
    endfunction
    function automatic logic [1:0] oe_exp(input logic [1:0] m);
        return ~m; // mask low drives the byte
    endfunction
    // one command, then nop, watching a bounded window for its pulse
    task automatic cmd_wait(input logic [3:0] code, input logic ba, input logic a10, input int k);
        logic hit;
        hit = 1'b0;
        last_cmd = sct_pkg::SCT_CMD_DESEL;
        issue(1'b1, code, ba, a10);
        for (int j = 0; j < 4; j++) begin
            issue(1'b1, 4'h7, 1'b0, 1'b0);
            if (pulse(k) === 1'b1) hit = 1'b1;
            // only the edge right after the command carries its own code
            if (j == 0 && cmd_valid === 1'b1) last_cmd = cmd;
        end
        chk(hit, 1'b1);
        if (!hit) end_of_test();
    endtask
    task automatic mode_after(input logic cke, input logic [3:0] code, input sct_pkg::sct_mode_type m);
        issue(cke, code, 1'b0, 1'b0);
        repeat (3) issue(cke, 4'hf, 1'b0, 1'b0);
        chk(mode, m);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n_i = 1'b0;
        req = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 11'h0, 2'h0};
        dq = 16'($random(seed));
        wr_ready = 1'b1;
        num_errors = 0;
        cmp_count = 0;
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        chk(mode, sct_pkg::SCT_MODE_NORMAL);
        chk(bank_open, 2'h0);
        repeat (2) issue(1'b1, 4'h7, 1'b0, 1'b0);
        // activate, read, write, precharge, refresh and mode register set in turn, bank 0
        for (i = 0; i < 6; i++) begin
            cmd_wait(code_t[i], 1'b0, 1'b0, kind_t[i]);
            chk(last_cmd, exp_t[i]);
        end
        // refused commands leave the open bank as it is
        cmd_wait(4'h3, 1'b0, 1'b0, 0);
        cmd_wait(4'h3, 1'b0, 1'b0, 1);
        cmd_wait(4'h5, 1'b1, 1'b0, 1);
        cmd_wait(4'h0, 1'b0, 1'b0, 1);
        cmd_wait(4'h1, 1'b0, 1'b0, 1);
        chk(bank_open, 2'h1);
        // masked read with auto precharge: one byte driven, bank closes
        @(negedge clk_i) req.dqm = 2'h1;
        issue(1'b1, 4'h5, 1'b0, 1'b1);
        n = 0;
        repeat (8) begin
            issue(1'b1, 4'h7, 1'b0, 1'b0);
            if (dq_oe !== 2'h0) begin
                n++;
                chk(dq_oe, oe_exp(2'h1));
                chk(dq_o[15:8], rd_data[15:8]);
                chk(auto_pre, n < sct_pkg::BURST_LEN);
                chk(burst, n < sct_pkg::BURST_LEN);
            end
        end
        chk(n, sct_pkg::BURST_LEN);
        chk(bank_open, 2'h0);
        @(negedge clk_i) req.dqm = 2'h0;
        // single-bank then all-bank precharge
        cmd_wait(4'h3, 1'b0, 1'b0, 0);
        cmd_wait(4'h3, 1'b1, 1'b0, 0);
        cmd_wait(4'h2, 1'b1, 1'b0, 0);
        chk(bank_open, 2'h1);
        cmd_wait(4'h2, 1'b0, 1'b1, 0);
        chk(bank_open, 2'h0);
        // power-down request in mid-burst becomes clock suspend
        cmd_wait(4'h3, 1'b0, 1'b0, 0);
        issue(1'b1, 4'h5, 1'b0, 1'b0);
        mode_after(1'b0, 4'h7, sct_pkg::SCT_MODE_SUSPEND);
        mode_after(1'b1, 4'h7, sct_pkg::SCT_MODE_NORMAL);
        cmd_wait(4'h2, 1'b0, 1'b1, 0);
        // power down from idle, then self refresh held with junk commands
        mode_after(1'b0, 4'h7, sct_pkg::SCT_MODE_PDOWN);
        mode_after(1'b1, 4'h7, sct_pkg::SCT_MODE_NORMAL);
        mode_after(1'b0, 4'h1, sct_pkg::SCT_MODE_SREF);
        repeat (5) issue(1'b0, 4'($random(seed)), 1'b0, 1'b0);
        chk(mode, sct_pkg::SCT_MODE_SREF);
        mode_after(1'b1, 4'hf, sct_pkg::SCT_MODE_NORMAL);
        // fill the fifo past its depth with the drain stalled, then drain randomly
        repeat (8) issue(1'b1, 4'h7, 1'b0, 1'b0);
        wr_ready = 1'b0;
        cmd_wait(4'h3, 1'b0, 1'b0, 0);
        repeat (5) begin
            issue(1'b1, 4'h4, 1'b0, 1'b0);
            repeat (5) issue(1'b1, 4'h7, 1'b0, 1'b0);
        end
        chk(wr_valid, 1'b1);
        n = 0;
        for (i = 0; i < 400 && n < 20; i++) begin
            @(negedge clk_i);
            wr_ready = 1'($random(seed));
            if (wr_valid === 1'b1 && wr_ready) begin
                n++;
                chk(beat, {1'b0, dq, 2'h0});
            end
        end
        chk(n, 20);
        end_of_test();
    end
endmodule
